// *** verilog/rovp_map.svh ***
`ifndef ROVP_MAP_SVH
`define ROVP_MAP_SVH

// Register offsets (byte addresses, one 32-bit word each)
`define ROVP_CTRL_OFS       8'h00
`define ROVP_THRESH_OFS     8'h04
`define ROVP_DELAY_OFS      8'h08
`define ROVP_STATUS_OFS     8'h0C
`define ROVP_IRQ_STAT_OFS   8'h10
`define ROVP_IRQ_MASK_OFS   8'h14

// Control field positions
`define ROVP_CTRL_OPER_BIT  0
`define ROVP_CTRL_SONLY_BIT 1

// Status field positions
`define ROVP_ST_START_BIT   0
`define ROVP_ST_TRIP_BIT    1
`define ROVP_ST_GSTART_BIT  2
`define ROVP_ST_GTRIP_BIT   3
`define ROVP_ST_BLOCK_BIT   4

// Interrupt event positions
`define ROVP_EV_START_BIT   0
`define ROVP_EV_TRIP_BIT    1
`define ROVP_EV_W           2

// Reset values and setting ranges
`define ROVP_OPER_RST       1'b1
`define ROVP_SONLY_RST      1'b0
`define ROVP_THRESH_RST     7'h1E
`define ROVP_THRESH_MIN     7'h02
`define ROVP_THRESH_MAX     7'h3C
`define ROVP_DELAY_RST      16'h0064
`define ROVP_DELAY_MIN      16'h0000
`define ROVP_DELAY_MAX      16'hEA60

// Timing: one millisecond of delay at the 40 ns clock
`define ROVP_MS_NS          1000000
`define ROVP_CLK_NS         40
`define ROVP_MS_CYC         (`ROVP_MS_NS / `ROVP_CLK_NS)

`endif

// *** verilog/rovp_pkg.sv ***
package rovp_pkg;

  // Delay sequencing, Gray coded along idle -> timing -> tripped
  typedef enum logic [1:0] {
    ROVP_IDLE    = 2'b00,
    ROVP_TIMING  = 2'b01,
    ROVP_TRIPPED = 2'b11
  } rovp_state_t;

  // Operation setting
  typedef enum logic {
    ROVP_OFF = 1'b0,
    ROVP_ON  = 1'b1
  } rovp_oper_t;

endpackage

// *** verilog/rovp_timer_if.sv ***
`timescale 1ns/1ps
interface rovp_timer_if #(
  parameter int DLY_W = 16
);
  logic             run;
  logic [DLY_W-1:0] delay_ms;
  logic             expired;

  // Decision side drives run and delay, timer answers with expiry
  modport ctrl (output run, output delay_ms, input expired);
  modport tmr  (input run, input delay_ms, output expired);
endinterface

// *** verilog/rovp_timer.sv ***
`timescale 1ns/1ps
module rovp_timer #(
  parameter int MS_CYC = 25000,
  parameter int DLY_W  = 16
) (
  // Clock and reset
  input wire logic   clk,
  input wire logic   reset_n,
  // Timer handshake
  rovp_timer_if.tmr  tif
);
  localparam int PRE_W = (MS_CYC > 1) ? $clog2(MS_CYC) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYC - 1);

  logic [PRE_W-1:0] pre_q, pre_d;
  logic [DLY_W-1:0] ms_q, ms_d;
  logic             exp_q, exp_d;

  initial begin
    if (MS_CYC < 1) $error("rovp_timer: MS_CYC must be at least 1");
  end

  // Millisecond prescaler and count; a dropped run clears everything
  always_comb begin
    pre_d = pre_q;
    ms_d  = ms_q;
    exp_d = 1'b0;
    if (!tif.run) begin
      pre_d = '0;
      ms_d  = '0;
    end else if (ms_q >= tif.delay_ms) begin
      exp_d = 1'b1;
    end else if (pre_q == PRE_LAST) begin
      pre_d = '0;
      ms_d  = ms_q + DLY_W'(1);
    end else begin
      pre_d = pre_q + PRE_W'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= '0;
      ms_q  <= '0;
      exp_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      ms_q  <= ms_d;
      exp_q <= exp_d;
    end
  end

  assign tif.expired = exp_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  expire_clear_a : assert property (!tif.run |=> !exp_q)
    else $error("Timer expiry survived a dropped run");
  expire_cause_a : assert property (
    $rose(exp_q) |-> $past(ms_q) >= $past(tif.delay_ms))
    else $error("Timer expired before the delay count");
endmodule

// *** verilog/rovp_top.sv ***
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "rovp_map.svh"

module rovp_top #(
  parameter int MAG_W  = 16,
  parameter int FRAC_W = 8,
  parameter int MS_CYC = `ROVP_MS_CYC
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Measured residual voltage, percent of nominal in fixed point
  input  wire logic [MAG_W-1:0] residual_voltage_magnitude,
  input  wire logic             magnitude_valid,
  // User blocking logic
  input  wire logic             block_input,
  // Register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata_q,
  // Protection outputs
  output logic                  general_start_out_q,
  output logic                  general_trip_out_q,
  // Interrupt
  output logic                  irq_q
);
  localparam int DLY_W = 16;
  localparam int THR_W = 7;

  initial begin
    if (MAG_W < FRAC_W + THR_W) $error("rovp_top: MAG_W too narrow");
    if (MS_CYC < 1) $error("rovp_top: MS_CYC must be at least 1");
  end

  // Range check shared by the threshold and delay writes
  function automatic logic in_range(input logic [DLY_W-1:0] v,
                                    input logic [DLY_W-1:0] lo,
                                    input logic [DLY_W-1:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // Settings
  rovp_pkg::rovp_oper_t   function_operation_setting_q;
  rovp_pkg::rovp_oper_t   function_operation_setting_d;
  logic                   start_only_select_q, start_only_select_d;
  logic [THR_W-1:0]       start_threshold_percent_q;
  logic [THR_W-1:0]       start_threshold_percent_d;
  logic [DLY_W-1:0]       trip_delay_ms_q, trip_delay_ms_d;
  logic [`ROVP_EV_W-1:0]  irq_stat_q, irq_stat_d;
  logic [`ROVP_EV_W-1:0]  irq_mask_q, irq_mask_d;
  logic [31:0]            rdata_d;
  logic                   irq_d;

  // Decision state
  rovp_pkg::rovp_state_t  state_q, state_d;
  logic                   over_q, over_d;
  logic                   internal_start_status_q;
  logic                   internal_start_status_d;
  logic                   internal_trip_status;
  logic                   gen_start_d, gen_trip_d;
  logic                   active;
  logic [MAG_W-1:0]       thr_scaled;
  logic [`ROVP_EV_W-1:0]  events;

  rovp_timer_if #(.DLY_W(DLY_W)) tif ();

  rovp_timer #(
    .MS_CYC (MS_CYC),
    .DLY_W  (DLY_W)
  ) u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .tif     (tif)
  );

  // Threshold in the magnitude's fixed-point scale
  assign thr_scaled = MAG_W'(start_threshold_percent_q) << FRAC_W;
  assign active = (function_operation_setting_q == rovp_pkg::ROVP_ON)
                  && !block_input;

  // Overvoltage comparison, held between magnitude updates
  always_comb begin
    over_d = over_q;
    if (magnitude_valid) begin
      over_d = residual_voltage_magnitude > thr_scaled;
    end
    internal_start_status_d = active && over_d;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      over_q                  <= 1'b0;
      internal_start_status_q <= 1'b0;
    end else begin
      over_q                  <= over_d;
      internal_start_status_q <= internal_start_status_d;
    end
  end

  // Timer runs only while started, so a drop clears it
  assign tif.run      = internal_start_status_q;
  assign tif.delay_ms = trip_delay_ms_q;

  // Delay sequencing; delay is fixed, magnitude only gates the start
  always_comb begin
    state_d = state_q;
    case (state_q)
      rovp_pkg::ROVP_IDLE: begin
        if (internal_start_status_q) state_d = rovp_pkg::ROVP_TIMING;
      end
      rovp_pkg::ROVP_TIMING: begin
        if (!internal_start_status_q) begin
          state_d = rovp_pkg::ROVP_IDLE;
        end else if (tif.expired) begin
          state_d = rovp_pkg::ROVP_TRIPPED;
        end
      end
      rovp_pkg::ROVP_TRIPPED: begin
        if (!internal_start_status_q) state_d = rovp_pkg::ROVP_IDLE;
      end
      default: state_d = rovp_pkg::ROVP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= rovp_pkg::ROVP_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign internal_trip_status = (state_q == rovp_pkg::ROVP_TRIPPED);

  // General outputs; start-only masks trip, not start
  always_comb begin
    gen_start_d = internal_start_status_q;
    gen_trip_d  = internal_trip_status && internal_start_status_q
                  && !start_only_select_q;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      general_start_out_q <= 1'b0;
      general_trip_out_q  <= 1'b0;
    end else begin
      general_start_out_q <= gen_start_d;
      general_trip_out_q  <= gen_trip_d;
    end
  end

  // Rising general outputs are the interrupt events
  assign events[`ROVP_EV_START_BIT] = gen_start_d && !general_start_out_q;
  assign events[`ROVP_EV_TRIP_BIT]  = gen_trip_d && !general_trip_out_q;

  // Register file; out-of-range settings are ignored, not clamped,
  // so software can spot a rejected write by reading back
  always_comb begin
    function_operation_setting_d = function_operation_setting_q;
    start_only_select_d          = start_only_select_q;
    start_threshold_percent_d    = start_threshold_percent_q;
    trip_delay_ms_d              = trip_delay_ms_q;
    irq_mask_d                   = irq_mask_q;
    irq_stat_d                   = irq_stat_q;
    rdata_d                      = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        `ROVP_CTRL_OFS: begin
          function_operation_setting_d = rovp_pkg::rovp_oper_t'(
            reg_wdata[`ROVP_CTRL_OPER_BIT]);
          start_only_select_d = reg_wdata[`ROVP_CTRL_SONLY_BIT];
        end
        `ROVP_THRESH_OFS: begin
          if (reg_wdata[31:THR_W] == '0 &&
              in_range(DLY_W'(reg_wdata[THR_W-1:0]),
                       DLY_W'(`ROVP_THRESH_MIN),
                       DLY_W'(`ROVP_THRESH_MAX))) begin
            start_threshold_percent_d = reg_wdata[THR_W-1:0];
          end
        end
        `ROVP_DELAY_OFS: begin
          if (reg_wdata[31:DLY_W] == '0 &&
              in_range(reg_wdata[DLY_W-1:0], `ROVP_DELAY_MIN,
                       `ROVP_DELAY_MAX)) begin
            trip_delay_ms_d = reg_wdata[DLY_W-1:0];
          end
        end
        `ROVP_IRQ_STAT_OFS: begin
          irq_stat_d = irq_stat_q & ~reg_wdata[`ROVP_EV_W-1:0];
        end
        `ROVP_IRQ_MASK_OFS: begin
          irq_mask_d = reg_wdata[`ROVP_EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // Set after clear so a same-cycle event is never lost
    irq_stat_d = irq_stat_d | events;
    if (reg_rd) begin
      case (reg_addr)
        `ROVP_CTRL_OFS: begin
          rdata_d[`ROVP_CTRL_OPER_BIT]  = function_operation_setting_q;
          rdata_d[`ROVP_CTRL_SONLY_BIT] = start_only_select_q;
        end
        `ROVP_THRESH_OFS: rdata_d[THR_W-1:0] = start_threshold_percent_q;
        `ROVP_DELAY_OFS:  rdata_d[DLY_W-1:0] = trip_delay_ms_q;
        `ROVP_STATUS_OFS: begin
          rdata_d[`ROVP_ST_START_BIT]  = internal_start_status_q;
          rdata_d[`ROVP_ST_TRIP_BIT]   = internal_trip_status;
          rdata_d[`ROVP_ST_GSTART_BIT] = general_start_out_q;
          rdata_d[`ROVP_ST_GTRIP_BIT]  = general_trip_out_q;
          rdata_d[`ROVP_ST_BLOCK_BIT]  = block_input;
        end
        `ROVP_IRQ_STAT_OFS: rdata_d[`ROVP_EV_W-1:0] = irq_stat_q;
        `ROVP_IRQ_MASK_OFS: rdata_d[`ROVP_EV_W-1:0] = irq_mask_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      function_operation_setting_q <= rovp_pkg::rovp_oper_t'(`ROVP_OPER_RST);
      start_only_select_q          <= `ROVP_SONLY_RST;
      start_threshold_percent_q    <= `ROVP_THRESH_RST;
      trip_delay_ms_q              <= `ROVP_DELAY_RST;
      irq_stat_q                   <= '0;
      irq_mask_q                   <= '0;
      reg_rdata_q                  <= 32'h0000_0000;
      irq_q                        <= 1'b0;
    end else begin
      function_operation_setting_q <= function_operation_setting_d;
      start_only_select_q          <= start_only_select_d;
      start_threshold_percent_q    <= start_threshold_percent_d;
      trip_delay_ms_q              <= trip_delay_ms_d;
      irq_stat_q                   <= irq_stat_d;
      irq_mask_q                   <= irq_mask_d;
      reg_rdata_q                  <= rdata_d;
      irq_q                        <= irq_d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_over_active;
    magnitude_valid && (residual_voltage_magnitude > thr_scaled) && active;
  endsequence

  sequence s_expired_started;
    internal_start_status_q && tif.expired;
  endsequence

  start_on_over_a : assert property (
    s_over_active |=> ##1 general_start_out_q)
    else $error("General start missing two cycles after overvoltage");
  start_on_under_a : assert property (
    magnitude_valid && !(residual_voltage_magnitude > thr_scaled)
    |=> !internal_start_status_q)
    else $error("Start set without overvoltage");
  thresh_range_a : assert property (
    start_threshold_percent_q >= `ROVP_THRESH_MIN &&
    start_threshold_percent_q <= `ROVP_THRESH_MAX)
    else $error("Threshold outside its range");
  oper_off_a : assert property (
    function_operation_setting_q == rovp_pkg::ROVP_OFF
    |=> ##1 !general_start_out_q && !general_trip_out_q)
    else $error("Output active while operation is off");
  delay_range_a : assert property (
    trip_delay_ms_q <= `ROVP_DELAY_MAX)
    else $error("Delay outside its range");
  trip_after_exp_a : assert property (
    s_expired_started ##1 internal_start_status_q
    |-> internal_trip_status)
    else $error("Trip status missing after delay expiry");
  trip_cause_a : assert property (
    $rose(internal_trip_status) |-> $past(tif.expired))
    else $error("Trip status rose without delay expiry");
  start_only_a : assert property (
    start_only_select_q |=> !general_trip_out_q)
    else $error("General trip while start-only selected");
  block_a : assert property (
    block_input |=> ##1 !general_start_out_q && !general_trip_out_q)
    else $error("Output active while blocked");
  gen_follow_a : assert property (
    general_start_out_q == $past(internal_start_status_q))
    else $error("General start does not follow start status");
  drop_clear_a : assert property (
    !internal_start_status_q
    |=> state_q == rovp_pkg::ROVP_IDLE ##1 !general_trip_out_q)
    else $error("Trip or timing survived a dropped start");
  // A new event must survive a same-cycle clear
  irq_sticky_a : assert property (
    (|events) |=> ((irq_stat_q & $past(events)) == $past(events)))
    else $error("Interrupt event lost before it was stored");
endmodule

// *** sim/rovp_src_model.sv ***
`timescale 1ns/1ps
module rovp_src_model #(
  parameter int MAG_W = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Commands from the bench
  input  wire logic [MAG_W-1:0] level_cmd,
  input  wire logic             block_cmd,
  input  wire logic [3:0]       gap_cmd,
  // Toward the protection block
  output logic      [MAG_W-1:0] residual_voltage_magnitude,
  output logic                  magnitude_valid,
  output logic                  block_input
);
  logic [3:0] cnt_q;

  // Periodic magnitude update; a wide gap mimics a slow filter stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q                      <= 4'h0;
      magnitude_valid            <= 1'b0;
      residual_voltage_magnitude <= '0;
      block_input                <= 1'b0;
    end else begin
      block_input     <= block_cmd;
      magnitude_valid <= 1'b0;
      if (cnt_q >= gap_cmd) begin
        cnt_q                      <= 4'h0;
        magnitude_valid            <= 1'b1;
        residual_voltage_magnitude <= level_cmd;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`include "rovp_map.svh"
module tb_top;
  localparam int MSC = 4;
  localparam int DLY = 2;
  logic        clk;
  logic        reset_n;
  logic [15:0] mag;
  logic        mag_vld;
  logic        blk;
  logic [15:0] level_cmd;
  logic        block_cmd;
  logic [3:0]  gap_cmd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata_q;
  logic        gs;
  logic        gt;
  logic        irq_q;
  int          num_errors;
  int          samples_checked;

  rovp_src_model src_u (.clk(clk), .reset_n(reset_n),
    .level_cmd(level_cmd), .block_cmd(block_cmd), .gap_cmd(gap_cmd),
    .residual_voltage_magnitude(mag), .magnitude_valid(mag_vld),
    .block_input(blk));

  rovp_top #(.MS_CYC(MSC)) dut_u (.clk(clk), .reset_n(reset_n),
    .residual_voltage_magnitude(mag), .magnitude_valid(mag_vld),
    .block_input(blk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .general_start_out_q(gs), .general_trip_out_q(gt), .irq_q(irq_q));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Settled sampling: let the edge's updates land first
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic read_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk_word(reg_rdata_q, e);
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] w,
                        input logic [31:0] e);
    reg_write(a, w);
    read_chk(a, e);
  endtask

  task automatic set_src(input logic [15:0] lv, input logic b);
    @(posedge clk);
    level_cmd <= lv;
    block_cmd <= b;
  endtask

  // Bounded wait on one output; steps off the edge before looking
  task automatic wait_out(input logic trip_sel, input logic v);
    #1;
    for (int i = 0; i < 40; i++) begin
      if ((trip_sel ? gt : gs) === v) break;
      tick(1);
    end
  endtask

  // Watchdog sized well beyond the whole sequence
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    reset_n         = 1'b0;
    reg_addr        = 8'h00;
    reg_wdata       = 32'h0000_0000;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    level_cmd       = 16'h0000;
    block_cmd       = 1'b0;
    gap_cmd         = 4'h2;
    num_errors      = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    // Reset values and an unmapped place
    read_chk(`ROVP_CTRL_OFS, 32'h0000_0001);
    read_chk(`ROVP_THRESH_OFS, 32'h0000_001E);
    read_chk(`ROVP_DELAY_OFS, 32'h0000_0064);
    read_chk(`ROVP_IRQ_MASK_OFS, 32'h0000_0000);
    read_chk(8'h18, 32'h0000_0000);
    // Setting limits: out-of-range writes leave the old value
    wr_chk(`ROVP_THRESH_OFS, 32'h0000_0001, 32'h0000_001E);
    wr_chk(`ROVP_THRESH_OFS, 32'h0000_003D, 32'h0000_001E);
    wr_chk(`ROVP_THRESH_OFS, 32'h0000_003C, 32'h0000_003C);
    wr_chk(`ROVP_THRESH_OFS, 32'h0000_0002, 32'h0000_0002);
    wr_chk(`ROVP_DELAY_OFS, 32'h0000_EA61, 32'h0000_0064);
    wr_chk(`ROVP_DELAY_OFS, 32'h0000_EA60, 32'h0000_EA60);
    wr_chk(`ROVP_DELAY_OFS, DLY, DLY);
    // Equal to threshold is not over it; one LSB above starts
    set_src(16'h0200, 1'b0);
    tick(12);
    chk_bit(gs, 1'b0);
    set_src(16'h0201, 1'b0);
    wait_out(1'b0, 1'b1);
    chk_bit(gs, 1'b1);
    tick(DLY * MSC);
    chk_bit(gt, 1'b0);
    tick(2);
    chk_bit(gt, 1'b1);
    read_chk(`ROVP_STATUS_OFS, 32'h0000_000F);
    // Sticky events, mask and write-one-to-clear
    read_chk(`ROVP_IRQ_STAT_OFS, 32'h0000_0003);
    chk_bit(irq_q, 1'b0);
    reg_write(`ROVP_IRQ_MASK_OFS, 32'h0000_0002);
    tick(2);
    chk_bit(irq_q, 1'b1);
    reg_write(`ROVP_IRQ_STAT_OFS, 32'h0000_0003);
    tick(2);
    chk_bit(irq_q, 1'b0);
    read_chk(`ROVP_IRQ_STAT_OFS, 32'h0000_0000);
    // Drop clears outputs; the timer restarts from zero
    set_src(16'h0100, 1'b0);
    wait_out(1'b0, 1'b0);
    chk_bit(gs, 1'b0);
    tick(1);
    chk_bit(gt, 1'b0);
    set_src(16'h0201, 1'b0);
    wait_out(1'b0, 1'b1);
    tick(DLY * MSC);
    chk_bit(gt, 1'b0);
    tick(2);
    chk_bit(gt, 1'b1);
    tick(3);
    chk_bit(irq_q, 1'b1);
    // Start only: start stays, trip held low
    reg_write(`ROVP_CTRL_OFS, 32'h0000_0003);
    tick(20);
    chk_bit(gt, 1'b0);
    chk_bit(gs, 1'b1);
    // Blocking with a slow source
    reg_write(`ROVP_CTRL_OFS, 32'h0000_0001);
    gap_cmd <= 4'h9;
    set_src(16'h0201, 1'b1);
    wait_out(1'b0, 1'b0);
    chk_bit(gs, 1'b0);
    tick(DLY * MSC + 4);
    chk_bit(gt, 1'b0);
    read_chk(`ROVP_STATUS_OFS, 32'h0000_0010);
    // Read data stands one cycle only, then returns to zero
    tick(1);
    chk_word(reg_rdata_q, 32'h0000_0000);
    set_src(16'h0201, 1'b0);
    wait_out(1'b0, 1'b1);
    chk_bit(gs, 1'b1);
    // Operation off silences the function
    reg_write(`ROVP_CTRL_OFS, 32'h0000_0000);
    wait_out(1'b0, 1'b0);
    chk_bit(gs, 1'b0);
    tick(DLY * MSC + 4);
    chk_bit(gt, 1'b0);
    // Zero delay trips two cycles after general start
    reg_write(`ROVP_DELAY_OFS, 32'h0000_0000);
    reg_write(`ROVP_CTRL_OFS, 32'h0000_0001);
    wait_out(1'b0, 1'b1);
    tick(1);
    chk_bit(gt, 1'b0);
    tick(1);
    chk_bit(gt, 1'b1);
    // Reset in mid-run drops the outputs and restores the settings
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    chk_bit(gs, 1'b0);
    chk_bit(gt, 1'b0);
    chk_bit(irq_q, 1'b0);
    read_chk(`ROVP_CTRL_OFS, 32'h0000_0001);
    read_chk(`ROVP_THRESH_OFS, 32'h0000_001E);
    read_chk(`ROVP_DELAY_OFS, 32'h0000_0064);
    read_chk(`ROVP_IRQ_STAT_OFS, 32'h0000_0000);
    report_and_stop();
  end
endmodule
